// [ahi_cfg.svh]
`ifndef AHI_CFG_SVH
`define AHI_CFG_SVH
// Register byte offsets within the slave window.
`define AHI_ADDR_W 12
`define AHI_STAT_OFS 12'h000
`define AHI_TMR_OFS 12'h004
`define AHI_CTRL_OFS 12'h008
`define AHI_RAW_OFS 12'h00c
// Channel DMA status register fields.
`define AHI_ST_ACT 0
`define AHI_ST_ERR 1
`define AHI_ST_DONE 2
`define AHI_ST_TMO 3
// Control register fields.
`define AHI_CTRL_RUN 0
// Raw state register fields.
`define AHI_RAW_WAIT 0
`define AHI_RAW_IRQ 1
`define AHI_RAW_STL 2
`define AHI_RAW_STH 3
`define AHI_RAW_CNTL 16
`define AHI_RAW_CNTH 31
// Ready timer width and reset value.
`define AHI_TMR_W 16
`define AHI_TMR_RST 16'h0000
`define AHI_TMR_ONE 16'h0001
// Pin synchroniser width and bit positions.
`define AHI_SYNC_W 2
`define AHI_SYNC_WAIT 0
`define AHI_SYNC_IRQ 1
// Bus encodings.
`define AHI_HSIZE_WORD 3'b010
`define AHI_HTRANS_NONSEQ 2'b10
`define AHI_HTRANS_SEQ 2'b11
`endif

// [ahi_pkg.sv]
`include "ahi_cfg.svh"
package ahi_pkg;
   typedef logic [`AHI_TMR_W-1:0] ahi_cnt_t;
   typedef enum logic [1:0] {
      AHI_T_IDLE    = 2'b00,
      AHI_T_COUNT   = 2'b01,
      AHI_T_EXPIRED = 2'b10
   } ahi_tmr_state_t;
endpackage

// [ahi_tmr_if.sv]
`timescale 1ns/1ps
interface ahi_tmr_if;
   import ahi_pkg::*;
   ahi_cnt_t       reload;
   logic           pio_busy;
   logic           wait_lvl;
   logic           expire;
   ahi_cnt_t       count;
   ahi_tmr_state_t state;
   modport ctl (output reload, output pio_busy, output wait_lvl,
                input expire, input count, input state);
   modport tmr (input reload, input pio_busy, input wait_lvl,
                output expire, output count, output state);
endinterface

// [ahi_sync.sv]
`timescale 1ns/1ps
`include "ahi_cfg.svh"
module ahi_sync
   import ahi_pkg::*;
(
   // Clock and control
   input  wire logic                   clock,
   input  wire logic                   reset,
   input  wire logic                   clk_en,
   // Asynchronous inputs and their synchronised copies
   input  wire logic [`AHI_SYNC_W-1:0] d,
   output logic      [`AHI_SYNC_W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < `AHI_SYNC_W; i = i + 1) begin : g_bit
         logic meta_r;
         logic stab_r;
         always_ff @(posedge clock) begin
            if (reset) begin
               meta_r <= 1'b0;
               stab_r <= 1'b0;
            end else if (clk_en) begin
               meta_r <= d[i];
               stab_r <= meta_r;
            end
         end
         assign q[i] = stab_r;
      end
   endgenerate
endmodule // ahi_sync

// [ahi_ready_timer.sv]
`timescale 1ns/1ps
`include "ahi_cfg.svh"
module ahi_ready_timer
   import ahi_pkg::*;
(
   // Clock and control
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic clk_en,
   // Timer connection
   ahi_tmr_if.tmr    tif
);
   ahi_tmr_state_t state_r;
   ahi_tmr_state_t state_nxt;
   ahi_cnt_t       cnt_r;
   ahi_cnt_t       cnt_nxt;
   logic           expire_r;
   logic           expire_nxt;
   logic           armed;

   assign armed = (tif.reload != `AHI_TMR_RST);

   always_comb begin
      state_nxt  = state_r;
      cnt_nxt    = cnt_r;
      expire_nxt = 1'b0;
      case (state_r)
         AHI_T_IDLE: begin
            cnt_nxt = tif.reload;
            if (armed && tif.wait_lvl && tif.pio_busy) begin
               state_nxt = AHI_T_COUNT;
            end
         end
         AHI_T_COUNT: begin
            if (!tif.wait_lvl || !tif.pio_busy) begin
               state_nxt = AHI_T_IDLE;
               cnt_nxt   = tif.reload;
            end else if (cnt_r == `AHI_TMR_ONE) begin
               state_nxt  = AHI_T_EXPIRED;
               cnt_nxt    = `AHI_TMR_RST;
               expire_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r - `AHI_TMR_ONE;
            end
         end
         AHI_T_EXPIRED: begin
            if (!tif.wait_lvl || !tif.pio_busy) begin
               state_nxt = AHI_T_IDLE;
               cnt_nxt   = tif.reload;
            end
         end
         default: begin
            state_nxt = AHI_T_IDLE;
            cnt_nxt   = tif.reload;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_r  <= AHI_T_IDLE;
         cnt_r    <= `AHI_TMR_RST;
         expire_r <= 1'b0;
      end else if (clk_en) begin
         state_r  <= state_nxt;
         cnt_r    <= cnt_nxt;
         expire_r <= expire_nxt;
      end
   end

   assign tif.expire = expire_r & clk_en;
   assign tif.count  = cnt_r;
   assign tif.state  = state_r;
endmodule // ahi_ready_timer

// [ahi_top.sv]
`timescale 1ns/1ps
`include "ahi_cfg.svh"
// Notes on behaviour
// - Timeout interrupt when wait outlasts armed timer.
// - Nonzero timer starts counting on wait assertion during a PIO cycle.
// - Expiry sets timeout flag and interrupt together.
// - Write one clears timeout flag and interrupt.
// - Supervise both control and data PIO cycles.
// - PIO drive interrupt passes through, no flags.
// - Drive holds request until status read.
// - DMA interrupt on drive request while active or after final word.
// - DMA completion interrupt sets done flag.
// - Write one clears done flag and interrupt.
// - Drive plus DMA give one DMA interrupt.
// - Running transfer: done 0, active 1, quiet.
// - Drive irq, descriptors exhausted: done 1, active 0.
// - Drive irq early: done 1, active 1, interrupt.
// - Short buffer: both flags 0, error flags failure.
// - Run bit stays set until firmware clears it.
module ahi_top
   import ahi_pkg::*;
(
   // Clock and control
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // AHB-Lite slave port
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Drive pins
   input  wire logic        ready_wait_pin,
   input  wire logic        drive_irq_pin,
   // PIO engine status
   input  wire logic        pio_reg_cycle,
   input  wire logic        pio_data_cycle,
   // DMA engine events
   input  wire logic        dma_final_word,
   input  wire logic        dma_mem_error,
   // System side
   output logic             cpu_irq,
   output logic             dma_run
);
   // Synchronised pin levels.
   logic [`AHI_SYNC_W-1:0]  pins_async;
   logic [`AHI_SYNC_W-1:0]  pins_sync;
   logic                    wait_s;
   logic                    irq_s;

   // Bus address phase capture.
   logic                    ap_valid_r;
   logic                    ap_write_r;
   logic [`AHI_ADDR_W-1:0]  ap_addr_r;
   logic [31:0]             rdata_r;
   logic [31:0]             rdata_nxt;
   logic                    ap_take;
   logic                    ap_word;

   // Decoded bus strobes: writes in the data phase, reads in the address phase.
   logic                    dp_write;
   logic                    wr_stat;
   logic                    wr_tmr;
   logic                    wr_ctrl;
   logic                    rd_stat;
   logic                    rd_tmr;
   logic                    rd_ctrl;
   logic                    rd_raw;
   logic [`AHI_ADDR_W-1:0]  ap_addr_in;

   // Software visible state.
   logic                    run_r;
   logic                    run_nxt;
   ahi_cnt_t                tmr_load_r;
   ahi_cnt_t                tmr_load_nxt;
   logic                    act_r;
   logic                    act_nxt;
   logic                    err_r;
   logic                    err_nxt;
   logic                    done_r;
   logic                    done_nxt;
   logic                    tmo_r;
   logic                    tmo_nxt;

   // Transfer tracking.
   logic                    run_q_r;
   logic                    fin_r;
   logic                    fin_nxt;
   logic                    drv_taken_r;
   logic                    drv_taken_nxt;
   logic                    run_rise;
   logic                    done_set;
   logic                    pio_irq;
   logic                    irq_r;
   logic                    irq_nxt;

   // Write-one-to-clear strobes.
   logic                    clr_done;
   logic                    clr_tmo;
   logic                    clr_err;

   // Status words assembled for readback.
   logic [31:0]             stat_word;
   logic [31:0]             ctrl_word;
   logic [31:0]             tmr_word;
   logic [31:0]             raw_word;

   ahi_tmr_if               tif ();

   assign pins_async[`AHI_SYNC_WAIT] = ready_wait_pin;
   assign pins_async[`AHI_SYNC_IRQ]  = drive_irq_pin;

   ahi_sync u_sync (
      .clock  (clock),
      .reset  (reset),
      .clk_en (clk_en),
      .d      (pins_async),
      .q      (pins_sync)
   );

   assign wait_s = pins_sync[`AHI_SYNC_WAIT];
   assign irq_s  = pins_sync[`AHI_SYNC_IRQ];

   // Ready timer supervision.
   assign tif.reload   = tmr_load_r;
   assign tif.pio_busy = pio_reg_cycle | pio_data_cycle;
   assign tif.wait_lvl = wait_s;

   ahi_ready_timer u_timer (
      .clock  (clock),
      .reset  (reset),
      .clk_en (clk_en),
      .tif    (tif)
   );

   // Address phase: zero wait states, so every transfer completes in one
   // data phase cycle and the response is always OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign ap_word   = (hsize == `AHI_HSIZE_WORD);
   assign ap_take   = hsel & hready & htrans[1] & ap_word;
   assign ap_addr_in = haddr[`AHI_ADDR_W-1:0];

   always_ff @(posedge clock) begin
      if (reset) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r  <= {`AHI_ADDR_W{1'b0}};
      end else if (clk_en && hready) begin
         ap_valid_r <= ap_take;
         ap_write_r <= hwrite;
         ap_addr_r  <= ap_addr_in;
      end
   end

   // Data phase write decode.
   assign dp_write = ap_valid_r & ap_write_r;
   assign wr_stat  = dp_write & (ap_addr_r == `AHI_STAT_OFS);
   assign wr_tmr   = dp_write & (ap_addr_r == `AHI_TMR_OFS);
   assign wr_ctrl  = dp_write & (ap_addr_r == `AHI_CTRL_OFS);

   // Read decode happens in the address phase so that hrdata is a flop.
   assign rd_stat = ap_take & ~hwrite & (ap_addr_in == `AHI_STAT_OFS);
   assign rd_tmr  = ap_take & ~hwrite & (ap_addr_in == `AHI_TMR_OFS);
   assign rd_ctrl = ap_take & ~hwrite & (ap_addr_in == `AHI_CTRL_OFS);
   assign rd_raw  = ap_take & ~hwrite & (ap_addr_in == `AHI_RAW_OFS);

   assign clr_done = wr_stat & hwdata[`AHI_ST_DONE];
   assign clr_tmo  = wr_stat & hwdata[`AHI_ST_TMO];
   assign clr_err  = wr_stat & hwdata[`AHI_ST_ERR];

   // Control: the run bit is only ever changed by software.
   assign run_nxt      = wr_ctrl ? hwdata[`AHI_CTRL_RUN] : run_r;
   assign tmr_load_nxt = wr_tmr ? hwdata[`AHI_TMR_W-1:0] : tmr_load_r;
   assign run_rise     = run_r & ~run_q_r;

   // Active runs from the start of a transfer until the last word is moved,
   // a memory error ends it, or software drops the run bit.
   always_comb begin
      act_nxt = act_r;
      if (run_rise) begin
         act_nxt = 1'b1;
      end else if (!run_r || dma_final_word || dma_mem_error) begin
         act_nxt = 1'b0;
      end
   end

   always_comb begin
      fin_nxt = fin_r;
      if (run_rise) begin
         fin_nxt = 1'b0;
      end else if (act_r && dma_final_word && !dma_mem_error) begin
         fin_nxt = 1'b1;
      end
   end

   // The drive request is taken once per assertion, so a held request does
   // not refill the done flag after software clears it.
   assign done_set = run_r & irq_s & ~drv_taken_r & (act_r | fin_r);

   always_comb begin
      drv_taken_nxt = drv_taken_r;
      if (!irq_s || run_rise) begin
         drv_taken_nxt = 1'b0;
      end else if (done_set) begin
         drv_taken_nxt = 1'b1;
      end
   end

   // Sticky flags: a set in the same cycle as its clear wins.
   assign done_nxt = (done_r & ~clr_done) | done_set;
   assign tmo_nxt  = (tmo_r & ~clr_tmo) | tif.expire;
   assign err_nxt  = (err_r & ~clr_err) | (run_r & dma_mem_error);

   // A drive request outside a DMA transfer is a PIO interrupt and goes
   // straight to the CPU; during a transfer it only feeds the done flag.
   assign pio_irq = irq_s & ~run_r;

   // The CPU line follows the next flag values, so flag and line change on
   // the same edge.
   assign irq_nxt = done_nxt | tmo_nxt | pio_irq;

   always_ff @(posedge clock) begin
      if (reset) begin
         run_r      <= 1'b0;
         run_q_r    <= 1'b0;
         tmr_load_r <= `AHI_TMR_RST;
      end else if (clk_en) begin
         run_r      <= run_nxt;
         run_q_r    <= run_r;
         tmr_load_r <= tmr_load_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         act_r       <= 1'b0;
         fin_r       <= 1'b0;
         drv_taken_r <= 1'b0;
      end else if (clk_en) begin
         act_r       <= act_nxt;
         fin_r       <= fin_nxt;
         drv_taken_r <= drv_taken_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         done_r <= 1'b0;
         tmo_r  <= 1'b0;
         err_r  <= 1'b0;
         irq_r  <= 1'b0;
      end else if (clk_en) begin
         done_r <= done_nxt;
         tmo_r  <= tmo_nxt;
         err_r  <= err_nxt;
         irq_r  <= irq_nxt;
      end
   end

   // Readback words.
   always_comb begin
      stat_word                = 32'h0000_0000;
      stat_word[`AHI_ST_ACT]   = act_r;
      stat_word[`AHI_ST_ERR]   = err_r;
      stat_word[`AHI_ST_DONE]  = done_r;
      stat_word[`AHI_ST_TMO]   = tmo_r;
   end

   always_comb begin
      ctrl_word                = 32'h0000_0000;
      ctrl_word[`AHI_CTRL_RUN] = run_r;
   end

   always_comb begin
      tmr_word                   = 32'h0000_0000;
      tmr_word[`AHI_TMR_W-1:0]   = tmr_load_r;
   end

   always_comb begin
      raw_word                                  = 32'h0000_0000;
      raw_word[`AHI_RAW_WAIT]                   = wait_s;
      raw_word[`AHI_RAW_IRQ]                    = irq_s;
      raw_word[`AHI_RAW_STH:`AHI_RAW_STL]       = tif.state;
      raw_word[`AHI_RAW_CNTH:`AHI_RAW_CNTL]     = tif.count;
   end

   // Unmapped reads return zero.
   assign rdata_nxt = ({32{rd_stat}} & stat_word) |
                      ({32{rd_tmr}}  & tmr_word)  |
                      ({32{rd_ctrl}} & ctrl_word) |
                      ({32{rd_raw}}  & raw_word);

   always_ff @(posedge clock) begin
      if (reset) begin
         rdata_r <= 32'h0000_0000;
      end else if (clk_en && hready) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign hrdata  = rdata_r;
   assign cpu_irq = irq_r;
   assign dma_run = run_r;
endmodule // ahi_top

// [ahi_top_checker.sv]
`timescale 1ns/1ps
`include "ahi_cfg.svh"
module ahi_top_checker
   import ahi_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // Bus
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hreadyout,
   input  wire logic        hresp,
   input  wire logic [31:0] hrdata,
   // Pins and outputs
   input  wire logic        ready_wait_pin,
   input  wire logic        drive_irq_pin,
   input  wire logic        cpu_irq,
   input  wire logic        dma_run
);
   wire acc     = hsel && htrans[1] && hsize == `AHI_HSIZE_WORD;
   wire wr_stat = acc && hwrite && haddr[11:0] == `AHI_STAT_OFS;
   wire wr_ctrl = acc && hwrite && haddr[11:0] == `AHI_CTRL_OFS;
   wire rd_ctrl = acc && !hwrite && haddr[11:0] == `AHI_CTRL_OFS;
   wire rd_none = acc && !hwrite && haddr[11:0] > `AHI_RAW_OFS;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not OKAY");
   a_reset_quiet: assert property ($fell(reset) |-> !cpu_irq && !dma_run && hrdata == 32'h0)
      else $error("outputs not quiet after reset");
   a_pio_pass: assert property ((drive_irq_pin && !dma_run)[*4] |-> cpu_irq)
      else $error("drive request not passed to cpu");
   a_run_kept: assert property ($changed(dma_run) && !$past(reset) |-> $past(wr_ctrl, 2))
      else $error("run bit changed without a write");
   a_irq_fall: assert property ($fell(cpu_irq) && !$past(reset) |->
      $past(wr_stat, 2) || $past(wr_ctrl, 2) || $past(!drive_irq_pin, 3))
      else $error("cpu interrupt dropped without cause");
   a_irq_cause: assert property ($rose(cpu_irq) && !$past(reset) |->
      $past(drive_irq_pin, 3) || $past(ready_wait_pin, 4))
      else $error("cpu interrupt raised without cause");
   a_rd_unmapped: assert property (rd_none |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_rd_ctrl: assert property (rd_ctrl |=> hrdata == {31'h0, $past(dma_run)})
      else $error("control read differs from run bit");
endmodule // ahi_top_checker

bind ahi_top ahi_top_checker ahi_top_checker_inst (.clock, .reset, .hsel, .haddr, .htrans,
   .hwrite, .hsize, .hreadyout, .hresp, .hrdata, .ready_wait_pin, .drive_irq_pin, .cpu_irq,
   .dma_run);

// [ahi_drive_model.sv]
`timescale 1ns/1ps
module ahi_drive_model (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // Requests from the bench
   input  wire logic irq_enable,
   input  wire logic irq_event,
   input  wire logic status_read,
   input  wire logic hold_req,
   // Drive pins
   output logic      ready_wait_pin,
   output logic      drive_irq_pin
);
   logic irq_r;
   // The request stays up until the host reads the status register.
   always_ff @(posedge clock) begin
      if (reset || status_read) begin
         irq_r <= 1'b0;
      end else if (irq_event && irq_enable) begin
         irq_r <= 1'b1;
      end
   end
   assign drive_irq_pin  = irq_r;
   assign ready_wait_pin = hold_req;
endmodule // ahi_drive_model

// [tb_ata_host_interrupt_logic.sv]
`timescale 1ns/1ps
`include "ahi_cfg.svh"
module tb_ata_host_interrupt_logic;
   logic        clock, reset, hsel, hwrite, hready, hreadyout, hresp, cpu_irq, dma_run;
   logic        pio_reg_cycle, pio_data_cycle, rd_chk, irq_en, hold;
   logic        ready_wait_pin, drive_irq_pin;
   logic [3:0]  ev;
   logic [31:0] haddr, hwdata, hrdata, exp_v, seed, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] exp_q[$];
   int          error_cnt, n_tests, n, k, nt;
   assign hready = hreadyout;
   ahi_top ahi_top_inst (.clock, .reset, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .ready_wait_pin,
      .drive_irq_pin, .pio_reg_cycle, .pio_data_cycle, .dma_final_word(ev[2]),
      .dma_mem_error(ev[3]), .cpu_irq, .dma_run);
   ahi_drive_model ahi_drive_model_inst (.clock, .reset, .irq_enable(irq_en),
      .irq_event(ev[0]), .status_read(ev[1]), .hold_req(hold), .ready_wait_pin,
      .drive_irq_pin);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic rdy();
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("hready", 32'h0, 32'h1);
         final_report();
      end
   endtask
   // One single-word transfer; for a read, d is the value expected back.
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= `AHI_HTRANS_NONSEQ;
      rdy();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      if (!w) begin
         exp_q.push_back(d);
         rd_chk <= 1'b1;
      end
      rdy();
      rd_chk <= 1'b0;
   endtask
   task automatic irq_is(input int cyc, input logic e);
      repeat (cyc) @(posedge clock);
      #1;
      chk("cpu_irq", {31'h0, cpu_irq}, {31'h0, e});
   endtask
   task automatic pulse(input logic [3:0] m);
      ev <= m;
      @(posedge clock);
      ev <= 4'h0;
   endtask
   always @(posedge clock) begin
      if (rd_chk === 1'b1) begin
         exp_v = exp_q.pop_front();
         chk("hrdata", hrdata, exp_v);
      end
   end
   initial begin
      reset = 1'b1;
      {hsel, hwrite, pio_reg_cycle, pio_data_cycle, rd_chk, irq_en, hold} = 7'h0;
      {haddr, hwdata, htrans, ev} = '0;
      hsize = `AHI_HSIZE_WORD;
      error_cnt = 0;
      n_tests = 0;
      seed = 32'h909c7aa7;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      bus(0, `AHI_STAT_OFS, 32'h0);
      bus(0, `AHI_CTRL_OFS, 32'h0);
      r = xs();
      bus(1, `AHI_TMR_OFS, r);
      bus(0, `AHI_TMR_OFS, r & 32'hffff);
      bus(1, 12'h010, r);
      bus(0, 12'h010, 32'h0);
      nt = int'(xs() % 32'd8) + 3;
      bus(1, `AHI_TMR_OFS, nt);
      for (k = 0; k < 2; k++) begin
         pio_reg_cycle <= (k == 0);
         pio_data_cycle <= (k == 1);
         hold <= 1'b1;
         irq_is(nt, 1'b0);
         hold <= 1'b0;
         irq_is(nt + 6, 1'b0);
         hold <= 1'b1;
         irq_is(nt + 3, 1'b0);
         irq_is(1, 1'b1);
         bus(0, `AHI_STAT_OFS, 32'h8);
         bus(1, `AHI_STAT_OFS, 32'h8);
         irq_is(0, 1'b0);
         irq_is(2 * nt, 1'b0);
         hold <= 1'b0;
         irq_is(4, 1'b0);
      end
      pio_reg_cycle <= 1'b0;
      pio_data_cycle <= 1'b0;
      pulse(4'h1);
      irq_is(5, 1'b0);
      irq_en <= 1'b1;
      for (k = 0; k < 3; k++) begin
         pulse(4'h1);
         irq_is(4, 1'b1);
         bus(0, `AHI_STAT_OFS, 32'h0);
         pulse(4'h2);
         irq_is(4, 1'b0);
      end
      // Normal completion: descriptors run out, then the drive interrupts.
      bus(1, `AHI_CTRL_OFS, 32'h1);
      // Active follows the run bit one cycle later.
      irq_is(1, 1'b0);
      bus(0, `AHI_STAT_OFS, 32'h1);
      pulse(4'h4);
      bus(0, `AHI_STAT_OFS, 32'h0);
      irq_is(2, 1'b0);
      pulse(4'h1);
      irq_is(4, 1'b1);
      bus(0, `AHI_STAT_OFS, 32'h4);
      bus(0, `AHI_CTRL_OFS, 32'h1);
      pulse(4'h2);
      bus(1, `AHI_STAT_OFS, 32'h4);
      irq_is(0, 1'b0);
      bus(1, `AHI_CTRL_OFS, 32'h0);
      irq_is(4, 1'b0);
      // The drive interrupts before the descriptors are used up.
      bus(1, `AHI_CTRL_OFS, 32'h1);
      pulse(4'h1);
      irq_is(4, 1'b1);
      bus(0, `AHI_STAT_OFS, 32'h5);
      pulse(4'h2);
      bus(1, `AHI_STAT_OFS, 32'h4);
      bus(1, `AHI_CTRL_OFS, 32'h0);
      irq_is(4, 1'b0);
      // A memory failure ends the transfer without an interrupt.
      bus(1, `AHI_CTRL_OFS, 32'h1);
      // The failure must come after the transfer has started.
      irq_is(1, 1'b0);
      pulse(4'h8);
      bus(0, `AHI_STAT_OFS, 32'h2);
      pulse(4'h1);
      irq_is(4, 1'b0);
      pulse(4'h2);
      bus(1, `AHI_STAT_OFS, 32'h6);
      irq_is(4, 1'b0);
      bus(1, `AHI_CTRL_OFS, 32'h0);
      bus(0, `AHI_STAT_OFS, 32'h0);
      irq_is(4, 1'b0);
      final_report();
   end
endmodule // tb_ata_host_interrupt_logic
